// *** core/cpu_defs.svh ***
// constants for the register/memory and multiply decode of the cpu core
`ifndef CPU_DEFS_SVH
`define CPU_DEFS_SVH

// upper opcode nibble: addressing mode
`define MODE_NIB_IMM      4'hA
`define MODE_NIB_DIR      4'hB
`define MODE_NIB_EXT      4'hC
`define MODE_NIB_IX2      4'hD
`define MODE_NIB_IX1      4'hE
`define MODE_NIB_IX       4'hF

// lower opcode nibble: operation
`define LO_SUBTRACT       4'h0
`define LO_CMP_ACC        4'h1
`define LO_SUB_BORROW     4'h2
`define LO_CMP_INDEX      4'h3
`define LO_AND            4'h4
`define LO_BIT_TEST       4'h5
`define LO_LOAD_ACC       4'h6
`define LO_STORE_ACC      4'h7
`define LO_XOR_ACC        4'h8
`define LO_ADD_CARRY      4'h9
`define LO_OR_ACC         4'hA
`define LO_ADD            4'hB
`define LO_JUMP           4'hC
`define LO_JUMP_SUB       4'hD
`define LO_LOAD_INDEX     4'hE
`define LO_STORE_INDEX    4'hF

`define OPC_MULTIPLY      8'h42
`define CYC_MULTIPLY      4'hB
`define CYC_ILLEGAL       4'h2

// load-class cycle and byte counts per mode
`define CYC_IMM           4'h2
`define CYC_DIR           4'h3
`define CYC_EXT           4'h4
`define CYC_IX            4'h3
`define CYC_IX1           4'h4
`define CYC_IX2           4'h5
`define BYT_IMM           2'h2
`define BYT_DIR           2'h2
`define BYT_EXT           2'h3
`define BYT_IX            2'h1
`define BYT_IX1           2'h2
`define BYT_IX2           2'h3
`define BYT_INHERENT      2'h1
`define CYC_STORE_EXTRA   4'h1
`define CYC_JUMP_LESS     4'h1
`define CYC_JSR_EXTRA     4'h2

// condition code bits
`define CCR_C             0
`define CCR_Z             1
`define CCR_N             2
`define CCR_I             3
`define CCR_H             4
`define CCR_RESET         5'h08

`define SP_PAGE           10'h003
`define SP_RESET          6'h3F
`define RESET_PC          16'h0000
`define ZERO_PAGE         8'h00

`endif

// *** core/cpu_pkg.sv ***
// types shared by the decoder and the execution core
`default_nettype none
`include "cpu_defs.svh"
package cpu_pkg;

	typedef enum logic [3:0] {
		op_subtract             = `LO_SUBTRACT,
		op_compare_accumulator  = `LO_CMP_ACC,
		op_subtract_with_borrow = `LO_SUB_BORROW,
		op_compare_index        = `LO_CMP_INDEX,
		op_and                  = `LO_AND,
		op_bit_test             = `LO_BIT_TEST,
		op_load_accumulator     = `LO_LOAD_ACC,
		op_store_accumulator    = `LO_STORE_ACC,
		op_exclusive_or_acc     = `LO_XOR_ACC,
		op_add_with_carry       = `LO_ADD_CARRY,
		op_logical_or_acc       = `LO_OR_ACC,
		op_add                  = `LO_ADD,
		op_jump_unconditional   = `LO_JUMP,
		op_jump_subroutine      = `LO_JUMP_SUB,
		op_load_index           = `LO_LOAD_INDEX,
		op_store_index          = `LO_STORE_INDEX
	} op_t;

	typedef enum logic [2:0] {
		mode_immediate = 3'h0,
		mode_direct    = 3'h1,
		mode_extended  = 3'h2,
		mode_indexed   = 3'h3,
		mode_indexed8  = 3'h4,
		mode_indexed16 = 3'h5,
		mode_inherent  = 3'h6
	} mode_t;

	typedef struct packed {
		logic       legal;
		logic       is_mul;
		op_t        op;
		mode_t      mode;
		logic [1:0] bytes;
		logic [3:0] cycles;
	} dec_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} mem_req_t;

	typedef enum logic [2:0] {
		st_fetch = 3'b001,
		st_opnd  = 3'b010,
		st_pad   = 3'b100
	} state_t;

endpackage
`default_nettype wire

// *** core/regmem_core.sv ***
// register/memory and multiply execution core with cycle-exact timing
// How it works
// - opcode 42 multiplies index by accumulator, one byte, eleven cycles.
// - the 16-bit product overwrites accumulator and index as one pair.
// - add-with-carry sums accumulator, operand and carry; opcodes A9..D9.
// - subtract-with-borrow uses opcodes A2, B2, C2, F2, E2, D2.
// - exclusive-or opcodes A8..D8 take 2, 3, 4, 3, 4, 5 cycles.
// - compare opcodes A1..D1 set flags only; 2,2,3,1,2,3 bytes.
// - bit test A5..D5 updates flags, accumulator and memory untouched.
// - product high byte goes to index, low byte to accumulator.
// - jumps load the effective address into pc, indexed forms add the index register.
// - add and add-with-carry set half carry on a bit 3 carry.
// - a subroutine call pushes a two-byte return address.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_defs.svh"
module regmem_core
	import cpu_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] mem_rdata_i,
	output mem_req_t        mem_req_o,
	output logic [7:0]      acc_o,
	output logic [7:0]      idx_o,
	output logic [15:0]     pc_o,
	output logic [5:0]      sp_o,
	output logic [4:0]      ccr_o,
	output logic            done_o,
	output logic            illegal_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	state_t      state_ff, nxt_state;
	dec_t        dec_ff, nxt_dec, dec_now;
	logic [3:0]  cnt_ff, nxt_cnt;
	logic [1:0]  left_ff, nxt_left;
	logic [15:0] ops_ff, nxt_ops;
	logic [7:0]  acc_ff, nxt_acc;
	logic [7:0]  idx_ff, nxt_idx;
	logic [15:0] pc_ff, nxt_pc;
	logic [5:0]  sp_ff, nxt_sp;
	logic [4:0]  ccr_ff, nxt_ccr;
	logic        done_ff;
	logic        illegal_ff;

	regmem_decode u_decode (
		.opcode_i (mem_rdata_i),
		.dec_o    (dec_now)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencing decode

	wire logic [3:0] last_cyc = dec_ff.cycles - 4'h1;
	wire logic       at_last  = (cnt_ff == last_cyc);
	wire logic       in_opnd  = (state_ff == st_opnd);
	wire logic       in_pad   = (state_ff == st_pad);
	wire logic       in_fetch = (state_ff == st_fetch);
	// jumps on direct and extended finish on their last operand byte
	wire logic       final_c  = at_last &&
		(in_pad || (in_opnd && left_ff == 2'h1));
	wire logic       is_alu   = dec_ff.legal && !dec_ff.is_mul;
	wire logic       is_store = is_alu &&
		(dec_ff.op == op_store_accumulator || dec_ff.op == op_store_index);
	wire logic       is_jmp   = is_alu && dec_ff.op == op_jump_unconditional;
	wire logic       is_jsr   = is_alu && dec_ff.op == op_jump_subroutine;
	wire logic       is_read  = is_alu && !is_store && !is_jmp && !is_jsr;
	wire logic [1:0] need_now = (dec_now.mode == mode_immediate) ? 2'h0 :
		dec_now.bytes - 2'h1;

	// operand bytes, with the byte arriving this cycle folded in
	wire logic [15:0] opv = in_opnd ? {ops_ff[7:0], mem_rdata_i} : ops_ff;
	wire logic [15:0] x16 = {`ZERO_PAGE, idx_ff};
	logic [15:0]      ea;
	always_comb
	begin
		case (dec_ff.mode)
			mode_direct:    ea = {`ZERO_PAGE, opv[7:0]};
			mode_extended:  ea = opv;
			mode_indexed:   ea = x16;
			mode_indexed8:  ea = {`ZERO_PAGE, opv[7:0]} + x16;
			mode_indexed16: ea = opv + x16;
			default:        ea = pc_ff;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// memory request

	wire logic        data_rd  = final_c && is_read;
	wire logic        data_wr  = final_c && is_store;
	// return address low byte one cycle before the high byte
	wire logic        push_lo  = in_pad && is_jsr &&
		(cnt_ff == dec_ff.cycles - 4'h2);
	wire logic        push_hi  = final_c && is_jsr;
	wire logic [15:0] stk_addr = {`SP_PAGE, sp_ff};
	wire logic [15:0] rd_addr  = (dec_ff.mode == mode_immediate) ? pc_ff : ea;
	wire logic [7:0]  st_data  = (dec_ff.op == op_store_index) ?
		idx_ff : acc_ff;

	assign mem_req_o.rd    = in_fetch || in_opnd || data_rd;
	assign mem_req_o.wr    = data_wr || push_lo || push_hi;
	assign mem_req_o.addr  = (push_lo || push_hi) ? stk_addr :
		(data_rd ? rd_addr : (data_wr ? ea : pc_ff));
	assign mem_req_o.wdata = push_lo ? pc_ff[7:0] :
		(push_hi ? pc_ff[15:8] : st_data);

	////////////////////////////////////////////////////////////////////////
	// arithmetic

	wire logic [7:0] m    = mem_rdata_i;
	wire logic       cf   = ccr_ff[`CCR_C];
	wire logic       use_c = (dec_ff.op == op_add_with_carry) ||
		(dec_ff.op == op_subtract_with_borrow);
	wire logic [7:0] cin8 = {7'h00, use_c & cf};
	wire logic [8:0] sum9 = {1'b0, acc_ff} + {1'b0, m} +
		{1'b0, cin8};
	wire logic [4:0] half = {1'b0, acc_ff[3:0]} + {1'b0, m[3:0]} +
		{1'b0, cin8[3:0]};
	wire logic [7:0] lhs  = (dec_ff.op == op_compare_index) ? idx_ff : acc_ff;
	wire logic [8:0] dif9 = {1'b0, lhs} - {1'b0, m} -
		{1'b0, cin8};
	wire logic [15:0] prod = idx_ff * acc_ff;

	logic [7:0] res;
	logic       wr_a, wr_x, set_c, set_h;
	always_comb
	begin
		res   = m;
		wr_a  = 1'b0;
		wr_x  = 1'b0;
		set_c = 1'b0;
		set_h = 1'b0;
		case (dec_ff.op)
			op_subtract, op_subtract_with_borrow:
			begin
				res = dif9[7:0];
				wr_a = 1'b1;
				set_c = 1'b1;
			end
			op_compare_accumulator, op_compare_index:
			begin
				res = dif9[7:0];
				set_c = 1'b1;
			end
			op_add, op_add_with_carry:
			begin
				res = sum9[7:0];
				wr_a = 1'b1;
				set_c = 1'b1;
				set_h = 1'b1;
			end
			op_and:
			begin
				res = acc_ff & m;
				wr_a = 1'b1;
			end
			op_bit_test: res = acc_ff & m;
			op_exclusive_or_acc:
			begin
				res = acc_ff ^ m;
				wr_a = 1'b1;
			end
			op_logical_or_acc:
			begin
				res = acc_ff | m;
				wr_a = 1'b1;
			end
			op_load_accumulator: wr_a = 1'b1;
			op_load_index:       wr_x = 1'b1;
			op_store_accumulator, op_store_index: res = st_data;
			default: res = m;
		endcase
	end

	wire logic c_out = (dec_ff.op == op_add || dec_ff.op == op_add_with_carry)
		? sum9[8] : dif9[8];

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		nxt_state = state_ff;
		nxt_dec   = dec_ff;
		nxt_cnt   = cnt_ff + 4'h1;
		nxt_left  = left_ff;
		nxt_ops   = ops_ff;
		nxt_acc   = acc_ff;
		nxt_idx   = idx_ff;
		nxt_pc    = pc_ff;
		nxt_sp    = sp_ff;
		nxt_ccr   = ccr_ff;
		case (state_ff)
			st_fetch:
			begin
				nxt_dec   = dec_now;
				nxt_pc    = pc_ff + 16'h0001;
				nxt_cnt   = 4'h1;
				nxt_left  = need_now;
				nxt_state = (need_now != 2'h0) ? st_opnd : st_pad;
			end
			st_opnd:
			begin
				nxt_ops  = opv;
				nxt_pc   = pc_ff + 16'h0001;
				nxt_left = left_ff - 2'h1;
				if (left_ff == 2'h1)
					nxt_state = st_pad;
			end
			st_pad:
				nxt_state = st_pad;
			default:
				nxt_state = st_fetch;
		endcase
		if (push_lo)
			nxt_sp = sp_ff - 6'h01;
		if (final_c)
		begin
			nxt_state = st_fetch;
			if (dec_ff.is_mul)
			begin
				nxt_idx = prod[15:8];
				nxt_acc = prod[7:0];
				nxt_ccr[`CCR_H] = 1'b0;
				nxt_ccr[`CCR_C] = 1'b0;
			end
			else if (is_jmp || is_jsr)
			begin
				nxt_pc = ea;
				if (is_jsr)
					nxt_sp = sp_ff - 6'h01;
			end
			else if (is_read || is_store)
			begin
				if (dec_ff.mode == mode_immediate)
					nxt_pc = pc_ff + 16'h0001;
				if (wr_a)
					nxt_acc = res;
				if (wr_x)
					nxt_idx = res;
				nxt_ccr[`CCR_N] = res[7];
				nxt_ccr[`CCR_Z] = (res == 8'h00);
				if (set_c)
					nxt_ccr[`CCR_C] = c_out;
				if (set_h)
					nxt_ccr[`CCR_H] = half[4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_ff   <= st_fetch;
			dec_ff     <= '0;
			cnt_ff     <= 4'h0;
			left_ff    <= 2'h0;
			ops_ff     <= 16'h0000;
			acc_ff     <= 8'h00;
			idx_ff     <= 8'h00;
			pc_ff      <= `RESET_PC;
			sp_ff      <= `SP_RESET;
			ccr_ff     <= `CCR_RESET;
			done_ff    <= 1'b0;
			illegal_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			dec_ff     <= nxt_dec;
			cnt_ff     <= nxt_cnt;
			left_ff    <= nxt_left;
			ops_ff     <= nxt_ops;
			acc_ff     <= nxt_acc;
			idx_ff     <= nxt_idx;
			pc_ff      <= nxt_pc;
			sp_ff      <= nxt_sp;
			ccr_ff     <= nxt_ccr;
			done_ff    <= final_c;
			illegal_ff <= final_c && !dec_ff.legal;
		end
	end

	// unknown opcodes run as two-cycle, one-byte no-operations
	assign acc_o     = acc_ff;
	assign idx_o     = idx_ff;
	assign pc_o      = pc_ff;
	assign sp_o      = sp_ff;
	assign ccr_o     = ccr_ff;
	assign done_o    = done_ff;
	assign illegal_o = illegal_ff;

endmodule
`default_nettype wire

// *** core/regmem_decode.sv ***
// opcode to operation, mode, length and cycle count
`timescale 1ns/1ps
`default_nettype none
`include "cpu_defs.svh"
module regmem_decode
	import cpu_pkg::*;
(
	input  wire logic [7:0] opcode_i,
	output dec_t            dec_o
);

	wire logic [3:0] hi_nib = opcode_i[7:4];
	wire logic [3:0] lo_nib = opcode_i[3:0];
	wire logic       is_mul = (opcode_i == `OPC_MULTIPLY);
	wire logic       in_class = (hi_nib >= `MODE_NIB_IMM);
	wire logic       no_imm = (lo_nib == `LO_STORE_ACC) ||
		(lo_nib == `LO_STORE_INDEX) || (lo_nib == `LO_JUMP) ||
		(lo_nib == `LO_JUMP_SUB);
	wire logic       is_imm = (hi_nib == `MODE_NIB_IMM);
	logic [3:0]      base_cyc;
	logic [1:0]      base_byt;
	mode_t           mode;

	// upper nibble picks the mode and the load-class timing
	always_comb
	begin
		base_cyc = `CYC_ILLEGAL;
		base_byt = `BYT_INHERENT;
		mode     = mode_inherent;
		case (hi_nib)
			`MODE_NIB_IMM:
			begin
				mode = mode_immediate;
				base_cyc = `CYC_IMM;
				base_byt = `BYT_IMM;
			end
			`MODE_NIB_DIR:
			begin
				mode = mode_direct;
				base_cyc = `CYC_DIR;
				base_byt = `BYT_DIR;
			end
			`MODE_NIB_EXT:
			begin
				mode = mode_extended;
				base_cyc = `CYC_EXT;
				base_byt = `BYT_EXT;
			end
			`MODE_NIB_IX2:
			begin
				mode = mode_indexed16;
				base_cyc = `CYC_IX2;
				base_byt = `BYT_IX2;
			end
			`MODE_NIB_IX1:
			begin
				mode = mode_indexed8;
				base_cyc = `CYC_IX1;
				base_byt = `BYT_IX1;
			end
			`MODE_NIB_IX:
			begin
				mode = mode_indexed;
				base_cyc = `CYC_IX;
				base_byt = `BYT_IX;
			end
			default:
			begin
				mode = mode_inherent;
			end
		endcase
	end

	wire logic       legal = is_mul || (in_class && !(is_imm && no_imm));
	wire logic [3:0] cls_cyc =
		(lo_nib == `LO_STORE_ACC || lo_nib == `LO_STORE_INDEX) ?
			base_cyc + `CYC_STORE_EXTRA :
		(lo_nib == `LO_JUMP) ? base_cyc - `CYC_JUMP_LESS :
		(lo_nib == `LO_JUMP_SUB) ? base_cyc + `CYC_JSR_EXTRA :
		base_cyc;

	assign dec_o.legal  = legal;
	assign dec_o.is_mul = is_mul;
	assign dec_o.op     = op_t'(lo_nib);
	assign dec_o.mode   = is_mul ? mode_inherent : mode;
	assign dec_o.bytes  = (legal && !is_mul) ? base_byt : `BYT_INHERENT;
	assign dec_o.cycles = is_mul ? `CYC_MULTIPLY :
		(legal ? cls_cyc : `CYC_ILLEGAL);

endmodule
`default_nettype wire

// *** tb/prog_data_mem.sv ***
// zero-latency program and data memory facing the core
`timescale 1ns/1ps
`default_nettype none
module prog_data_mem
	import cpu_pkg::*;
(
	input  wire logic     clk_sys_i,
	input  wire mem_req_t req_i,
	output logic [7:0]    rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_ff = 8'h00;

	// off the bus the lines flip, so a stale byte never looks valid
	assign rdata_o = req_i.rd ? mem[req_i.addr] : ~last_ff;

	always @(posedge clk_sys_i)
	begin
		if (req_i.wr)
			mem[req_i.addr] <= req_i.wdata;
		if (req_i.rd)
			last_ff <= rdata_o;
	end
endmodule
`default_nettype wire

// *** tb/regmem_checker_assertions.sv ***
// checker: cycle counts, lengths and register effects of the core
`timescale 1ns/1ps
`default_nettype none
module regmem_checker
	import cpu_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rstn_i,
	input wire logic [7:0]  mem_rdata_i,
	input wire mem_req_t    mem_req_o,
	input wire logic [7:0]  acc_o,
	input wire logic [7:0]  idx_o,
	input wire logic [15:0] pc_o,
	input wire logic [5:0]  sp_o,
	input wire logic [4:0]  ccr_o,
	input wire logic        done_o,
	input wire logic        illegal_o
);
	function automatic logic legal(input logic [7:0] op);
		if (op == 8'h42)
			return 1'b1;
		if (op[7:4] == 4'hA)
			return !(op[3:0] inside {4'h7, 4'hC, 4'hD, 4'hF});
		return op[7:4] > 4'hA;
	endfunction

	function automatic logic [3:0] exp_cyc(input logic [7:0] op);
		logic [3:0] b;
		case (op[7:4])
			4'hA: b = 4'h2;
			4'hB, 4'hF: b = 4'h3;
			4'hD: b = 4'h5;
			default: b = 4'h4;
		endcase
		if (op == 8'h42)
			return 4'hB;
		if (!legal(op))
			return 4'h2;
		case (op[3:0])
			4'h7, 4'hF: return b + 4'h1;
			4'hC: return b - 4'h1;
			4'hD: return b + 4'h2;
			default: return b;
		endcase
	endfunction

	function automatic logic [15:0] exp_len(input logic [7:0] op);
		if (!legal(op) || op == 8'h42 || op[7:4] == 4'hF)
			return 16'h0001;
		return (op[7:4] inside {4'hC, 4'hD}) ? 16'h0003 : 16'h0002;
	endfunction

	logic        first_ff;
	logic [3:0]  cnt_ff;
	logic [7:0]  op_ff;
	logic [7:0]  acc_ff;
	logic [7:0]  idx_ff;
	logic [15:0] pc_ff;
	logic [5:0]  sp_ff;

	// opcode cycle: first after reset, else the cycle that shows done
	wire       opc = rstn_i && (done_o || first_ff);
	wire       ok  = legal(op_ff);
	wire [3:0] lo  = op_ff[3:0];
	wire       jump_unconditional = ok && (lo == 4'hC || lo == 4'hD);

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			first_ff <= 1'b1;
			cnt_ff <= 4'h0;
			op_ff <= 8'h00;
			acc_ff <= 8'h00;
			idx_ff <= 8'h00;
			pc_ff <= 16'h0000;
			sp_ff <= 6'h00;
		end
		else
		begin
			first_ff <= 1'b0;
			cnt_ff <= opc ? 4'h1 : cnt_ff + 4'h1;
			if (opc)
			begin
				op_ff <= mem_rdata_i;
				acc_ff <= acc_o;
				idx_ff <= idx_o;
				pc_ff <= pc_o;
				sp_ff <= sp_o;
			end
		end
	end

	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_mul_go;
		opc && mem_rdata_i == 8'h42;
	endsequence
	// ten quiet cycles after the opcode, split to keep the repeat short
	sequence s_mul_run;
		!done_o [*8] ##1 !done_o ##1 !done_o ##1 done_o;
	endsequence
	sequence s_push;
		mem_req_o.wr && mem_req_o.addr == {10'h003, sp_o};
	endsequence

	property p_cycles;
		done_o |-> cnt_ff == exp_cyc(op_ff);
	endproperty
	property p_mul_time;
		s_mul_go |=> s_mul_run;
	endproperty
	property p_mul_prod;
		done_o && op_ff == 8'h42 |-> {idx_o, acc_o} == 16'(idx_ff) * 16'(acc_ff)
			&& ccr_o[4] == 1'b0 && ccr_o[0] == 1'b0;
	endproperty
	property p_flags_only;
		done_o && ok && lo inside {4'h1, 4'h3, 4'h5}
			|-> acc_o == acc_ff && idx_o == idx_ff;
	endproperty
	property p_jump_regs;
		done_o && jump_unconditional |-> acc_o == acc_ff && idx_o == idx_ff;
	endproperty
	property p_length;
		done_o && !jump_unconditional |-> pc_o == pc_ff + exp_len(op_ff);
	endproperty
	property p_illegal;
		done_o |-> illegal_o == !ok;
	endproperty
	property p_jsr_sp;
		done_o && ok && lo == 4'hD |-> sp_o == sp_ff - 6'h02;
	endproperty
	property p_push;
		$rose(mem_req_o.wr) && ok && lo == 4'hD |-> s_push ##1 s_push ##1 done_o;
	endproperty

	a_cycles: assert property (p_cycles)
		else $error("instruction cycle count wrong");
	a_mul_time: assert property (p_mul_time)
		else $error("multiply did not take eleven cycles");
	a_mul_prod: assert property (p_mul_prod)
		else $error("multiply product or flags wrong");
	a_flags_only: assert property (p_flags_only)
		else $error("compare or bit test altered a register");
	a_jump_regs: assert property (p_jump_regs)
		else $error("jump altered a register");
	a_length: assert property (p_length)
		else $error("instruction length wrong");
	a_illegal: assert property (p_illegal)
		else $error("illegal flag wrong");
	a_jsr_sp: assert property (p_jsr_sp)
		else $error("call did not drop stack by two");
	a_push: assert property (p_push)
		else $error("return address push wrong");
endmodule

bind regmem_core regmem_checker regmem_checker_inst (
	.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i),
	.mem_rdata_i(mem_rdata_i),
	.mem_req_o(mem_req_o),
	.acc_o(acc_o),
	.idx_o(idx_o),
	.pc_o(pc_o),
	.sp_o(sp_o),
	.ccr_o(ccr_o),
	.done_o(done_o),
	.illegal_o(illegal_o)
);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the register/memory and multiply core
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cpu_pkg::*;
	typedef struct {
		logic [7:0] op, b1, b2;
		logic [3:0] len, cyc;
		logic [7:0] acc, idx;
		logic [4:0] ccr;
	} row_t;

	logic        clk_sys_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [7:0]  mem_rdata_i;
	mem_req_t    mem_req_o;
	logic [7:0]  acc_o;
	logic [7:0]  idx_o;
	logic [15:0] pc_o;
	logic [5:0]  sp_o;
	logic [4:0]  ccr_o;
	logic        done_o;
	logic        illegal_o;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;

	// program: jump targets are patched to the following row on load
	row_t rows [25] = '{
		'{8'hA6, 8'h0F, 8'h00, 4'h2, 4'h2, 8'h0F, 8'h00, 5'h08},
		'{8'hAB, 8'h01, 8'h00, 4'h2, 4'h2, 8'h10, 8'h00, 5'h18},
		'{8'hA9, 8'hF0, 8'h00, 4'h2, 4'h2, 8'h00, 8'h00, 5'h0B},
		'{8'hA9, 8'h00, 8'h00, 4'h2, 4'h2, 8'h01, 8'h00, 5'h08},
		'{8'hA2, 8'h02, 8'h00, 4'h2, 4'h2, 8'hFF, 8'h00, 5'h0D},
		'{8'hA2, 8'h00, 8'h00, 4'h2, 4'h2, 8'hFE, 8'h00, 5'h0C},
		'{8'hB8, 8'h80, 8'h00, 4'h2, 4'h3, 8'hF1, 8'h00, 5'h0C},
		'{8'hAE, 8'h80, 8'h00, 4'h2, 4'h2, 8'hF1, 8'h80, 5'h0C},
		'{8'hF8, 8'h00, 8'h00, 4'h1, 4'h3, 8'hFE, 8'h80, 5'h0C},
		'{8'hE8, 8'h01, 8'h00, 4'h2, 4'h4, 8'h01, 8'h80, 5'h08},
		'{8'hC8, 8'h00, 8'h81, 4'h3, 4'h4, 8'hFE, 8'h80, 5'h0C},
		'{8'hD8, 8'h00, 8'h00, 4'h3, 4'h5, 8'hF1, 8'h80, 5'h0C},
		'{8'hA8, 8'hF1, 8'h00, 4'h2, 4'h2, 8'h00, 8'h80, 5'h0A},
		'{8'hA1, 8'h00, 8'h00, 4'h2, 4'h2, 8'h00, 8'h80, 5'h0A},
		'{8'hF1, 8'h00, 8'h00, 4'h1, 4'h3, 8'h00, 8'h80, 5'h0D},
		'{8'hA6, 8'hF0, 8'h00, 4'h2, 4'h2, 8'hF0, 8'h80, 5'h0D},
		'{8'hE5, 8'h01, 8'h00, 4'h2, 4'h4, 8'hF0, 8'h80, 5'h0D},
		'{8'hA5, 8'h0F, 8'h00, 4'h2, 4'h2, 8'hF0, 8'h80, 5'h0B},
		'{8'hAE, 8'h10, 8'h00, 4'h2, 4'h2, 8'hF0, 8'h10, 5'h09},
		'{8'h42, 8'h00, 8'h00, 4'h1, 4'hB, 8'h00, 8'h0F, 5'h08},
		'{8'hCD, 8'h00, 8'h00, 4'h3, 4'h6, 8'h00, 8'h0F, 5'h08},
		'{8'hBC, 8'h00, 8'h00, 4'h2, 4'h2, 8'h00, 8'h0F, 5'h08},
		'{8'hB7, 8'h90, 8'h00, 4'h2, 4'h4, 8'h00, 8'h0F, 5'h0A},
		'{8'hA7, 8'h00, 8'h00, 4'h1, 4'h2, 8'h00, 8'h0F, 5'h0A},
		'{8'h9D, 8'h00, 8'h00, 4'h1, 4'h2, 8'h00, 8'h0F, 5'h0A}
	};

	regmem_core regmem_core_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o), .acc_o(acc_o),
		.idx_o(idx_o), .pc_o(pc_o), .sp_o(sp_o), .ccr_o(ccr_o),
		.done_o(done_o), .illegal_o(illegal_o));
	prog_data_mem prog_data_mem_inst (.clk_sys_i(clk_sys_i),
		.req_i(mem_req_o), .rdata_o(mem_rdata_i));

	always #5 clk_sys_i = ~clk_sys_i;

	////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [15:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic wait_done(output int n);
		n = 0;
		do
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		while (done_o !== 1'b1 && n < 40);
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////
	initial
	begin
		int a, n;
		logic [15:0] ret;
		logic ill;
		for (a = 0; a < 65536; a++)
			prog_data_mem_inst.mem[a] = 8'h00;
		a = 0;
		foreach (rows[i])
		begin
			if (rows[i].op == 8'hCD)
			begin
				ret = 16'(a + 3);
				{rows[i].b1, rows[i].b2} = ret;
			end
			if (rows[i].op == 8'hBC)
				rows[i].b1 = 8'(a + 2);
			prog_data_mem_inst.mem[a] = rows[i].op;
			prog_data_mem_inst.mem[a + 1] = rows[i].b1;
			prog_data_mem_inst.mem[a + 2] = rows[i].b2;
			a += int'(rows[i].len);
		end
		prog_data_mem_inst.mem[16'h0080] = 8'h0F;
		prog_data_mem_inst.mem[16'h0081] = 8'hFF;
		prog_data_mem_inst.mem[16'h0090] = 8'h5A;
		repeat (20) @(posedge clk_sys_i);
		#1 rstn_i = 1'b1;
		a = 0;
		foreach (rows[i])
		begin
			wait_done(n);
			ill = rows[i].op == 8'hA7 || rows[i].op == 8'h9D;
			a += int'(rows[i].len);
			check("cycles", 16'(rows[i].cyc), 16'(n));
			check("acc", 16'(rows[i].acc), 16'(acc_o));
			check("idx", 16'(rows[i].idx), 16'(idx_o));
			check("ccr", 16'(rows[i].ccr), 16'(ccr_o));
			check("pc", 16'(a), pc_o);
			check("illegal", 16'(ill), 16'(illegal_o));
		end
		$display("instruction table done");
		check("push_lo", 16'(ret[7:0]),
			16'(prog_data_mem_inst.mem[16'h00FF]));
		check("push_hi", 16'(ret[15:8]),
			16'(prog_data_mem_inst.mem[16'h00FE]));
		check("sp", 16'h003D, 16'(sp_o));
		check("store", 16'h0000,
			16'(prog_data_mem_inst.mem[16'h0090]));
		$display("stack and store done");
		repeat (3) @(posedge clk_sys_i);
		#1 rstn_i = 1'b0;
		#1;
		check("rst_acc", 16'h0000, {acc_o, idx_o});
		check("rst_pc", 16'h0000, pc_o);
		check("rst_sp", 16'h003F, 16'(sp_o));
		check("rst_ccr", 16'h0008, 16'(ccr_o));
		check("rst_flags", 16'h0000, 16'({done_o, illegal_o}));
		check("rst_req", 16'h0002, 16'({mem_req_o.rd, mem_req_o.wr}));
		check("rst_addr", 16'h0000, mem_req_o.addr);
		repeat (2) @(posedge clk_sys_i);
		#1 rstn_i = 1'b1;
		wait_done(n);
		check("rerun_cycles", 16'h0002, 16'(n));
		check("rerun_acc", 16'h000F, 16'(acc_o));
		$display("mid-run reset done");
		final_report();
	end
endmodule
`default_nettype wire
